// *** hw/lsoc_params.svh ***
// Purpose: Offsets, field positions, reset values for the sideband output control block
// Assumes: Byte addresses on a 32-bit AHB-Lite bus, one register per aligned word
// Notes:   Included by bare name; definitions only
`ifndef LSOC_PARAMS_SVH
`define LSOC_PARAMS_SVH

// Register byte offsets
`define LSOC_OFS_CTRL0      12'h000
`define LSOC_OFS_CTRL1      12'h004
`define LSOC_OFS_GATE       12'h008
`define LSOC_OFS_STAT       12'h00C

// Control register 0 fields
`define LSOC_C0_FGATE       4
`define LSOC_C0_SDWN        3
`define LSOC_C0_PME         2
`define LSOC_C0_SMI         1
`define LSOC_C0_SCI         0

// Control register 1 fields
`define LSOC_C1_SWRST       4
`define LSOC_C1_PMEL        2
`define LSOC_C1_SMIL        1
`define LSOC_C1_SCIL        0

// Gate register and status fields
`define LSOC_GATE_LVL       0
`define LSOC_ST_SHDN        0
`define LSOC_ST_PD          1
`define LSOC_ST_LRST        2
`define LSOC_ST_ARMED       3

// Reset values and masks
`define LSOC_CTRL_RST       8'h00
`define LSOC_C0_MASK        8'h1F
`define LSOC_C1_MASK        8'h17
`define LSOC_GATE_RST       1'b1

`endif

// *** hw/lsoc_pkg.sv ***
// Purpose: Types shared by the sideband output control block
// Assumes: AHB-Lite transfer encodings
// Notes:   Constants live in lsoc_params.svh
package lsoc_pkg;

  // AHB transfer type
  typedef enum logic [1:0] {
    HTRANS_IDLE   = 2'b00,
    HTRANS_BUSY   = 2'b01,
    HTRANS_NONSEQ = 2'b10,
    HTRANS_SEQ    = 2'b11
  } lsoc_htrans_type;

  // Interface shutdown state
  typedef enum logic {
    SHDN_RUN,
    SHDN_DOWN
  } lsoc_shdn_type;

endpackage

// *** hw/lsoc_od_pins.sv ***
// Purpose: Registered open-drain pin drivers with function select
// Assumes: Pin is pulled up outside; output enable high while driving
// Notes:   Output data is always 0, the pin is never driven high
`timescale 1ns/1ps
`default_nettype none

module lsoc_od_pins #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk,      // System clock
  input  wire logic             rstn,     // Async reset, active low
  input  wire logic [WIDTH-1:0] enable,   // Pin owned by this block
  input  wire logic [WIDTH-1:0] level,    // 0 pulls low, 1 releases
  output logic      [WIDTH-1:0] pinSel,   // 1 selects this function
  output logic      [WIDTH-1:0] pinOut,   // Output data, always low
  output logic      [WIDTH-1:0] pinOe     // Output enable
);

  logic [WIDTH-1:0] sel_q, sel_d, oe_q, oe_d;

  // Next pin state: drive low only when owned and level is 0
  always_comb begin
    sel_d = enable;
    oe_d  = enable & ~level;
  end

  // Pin state registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_q <= '0;
      oe_q  <= '0;
    end else begin
      sel_q <= sel_d;
      oe_q  <= oe_d;
    end
  end

  assign pinSel = sel_q;
  assign pinOe  = oe_q;
  assign pinOut = '0;   // Open drain: never high

endmodule

`default_nettype wire

// *** hw/lsoc_sideband.sv ***
// Purpose: Sideband output control bits of the host interface, on AHB-Lite
// Assumes: Pins pulled up outside; pin inputs asynchronous to clk
// Notes:   Zero wait states; read data registered at the address phase
//
// Operation
// (RULE1) Fast gate disabled: pin to other function, gate state held at 1.
// (RULE2) Fast gate enabled: gate pin is open drain, pulled up outside.
// (RULE3) Firmware must not set gate port pin direction while fast gate on.
// (RULE4) Fast gate off: firmware may make the gate with a plain port output.
// (RULE5) Shutdown enable clears on write 0, interface reset, shutdown release edge.
// (RULE6) Shutdown enable sets only on writing 1 after reading it as 0.
// (RULE7) Shutdown enable 1 and power-down low enters hardware shutdown.
// (RULE8) Power event enable 0: output off, pin to other function.
// (RULE9) Power event enable 1: level 0 drives low, level 1 releases.
// (RULE10) Management irq enable 0: output off regardless of level.
// (RULE11) Management irq enable 1: level 0 drives low, level 1 releases.
// (RULE12) Control irq enable 0: output off regardless of level.
// (RULE13) Control irq enable 1: level 0 drives low, level 1 releases.
// (RULE14) Sideband outputs are open drain only, never driven high.
// (RULE15) Firmware sets direction bit of each used sideband port pin.
// (RULE16) Control registers 0 and 1 clear on chip reset and standby.
// (RULE17) Enable bits read back as written, shutdown bit excepted.
`timescale 1ns/1ps
`default_nettype none
`include "lsoc_params.svh"

module lsoc_sideband
  import lsoc_pkg::*;
(
  input  wire logic        clk,             // 125 MHz system clock
  input  wire logic        rstn,            // Async chip reset, active low
  input  wire logic        hsel,            // AHB slave select
  input  wire logic [31:0] haddr,           // AHB address
  input  wire logic [1:0]  htrans,          // AHB transfer type
  input  wire logic        hwrite,          // AHB write
  input  wire logic [2:0]  hsize,           // AHB size
  input  wire logic        hready,          // AHB bus ready
  input  wire logic [31:0] hwdata,          // AHB write data
  output logic      [31:0] hrdata,          // AHB read data
  output logic             hreadyout,       // AHB slave ready
  output logic             hresp,           // AHB response, always OKAY
  input  wire logic        powerDownInN,    // Interface power-down pin, low active
  input  wire logic        lpcResetInN,     // Interface hardware reset pin
  input  wire logic        standbyInN,      // Hardware standby, low active
  output logic             hwShutdown,      // Interface in hardware shutdown
  output logic             addr20GateState, // Internal gate output state
  output logic             gatePinSel,      // Gate pin owned by fast gate
  output logic             gatePinOut,      // Gate pin data
  output logic             gatePinOe,       // Gate pin output enable
  output logic             pmePinSel,       // Power event pin owned
  output logic             pmePinOut,       // Power event pin data
  output logic             pmePinOe,        // Power event pin output enable
  output logic             smiPinSel,       // Management irq pin owned
  output logic             smiPinOut,       // Management irq pin data
  output logic             smiPinOe,        // Management irq pin output enable
  output logic             sciPinSel,       // Control irq pin owned
  output logic             sciPinOut,       // Control irq pin data
  output logic             sciPinOe         // Control irq pin output enable
);

  // Pin synchronisers: first stage read only by second
  logic [2:0] syncA_q, syncB_q;
  logic       pdPrev_q;
  logic       pdLevel, lpcRstActive, standby, pdRise;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncA_q  <= 3'h7;
      syncB_q  <= 3'h7;
      pdPrev_q <= 1'b1;
    end else begin
      syncA_q  <= {standbyInN, lpcResetInN, powerDownInN};
      syncB_q  <= syncA_q;
      pdPrev_q <= syncB_q[0];
    end
  end

  assign pdLevel      = syncB_q[0];
  assign lpcRstActive = ~syncB_q[1];
  assign standby      = ~syncB_q[2];
  assign pdRise       = pdLevel & ~pdPrev_q;

  // AHB address phase capture
  logic        wrPend_q, wrPend_d;
  logic [11:0] wrAddr_q, wrAddr_d;
  logic [31:0] rdata_q, rdata_d;
  logic        accept, rdAccept;
  logic [11:0] offs;

  logic [7:0]    ctrl0_q, ctrl0_d, ctrl1_q, ctrl1_d;
  logic          gateLvl_q, gateLvl_d;
  logic          armed_q, armed_d;
  lsoc_shdn_type shdn_q, shdn_d;
  logic          ifReset, wrCtrl0, wrCtrl1, wrGate;
  logic [7:0]    wd;

  assign accept   = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign rdAccept = accept & ~hwrite;
  assign offs     = {haddr[11:2], 2'b00};

  // Bus next state and registered read mux
  always_comb begin
    wrPend_d = accept & hwrite;
    wrAddr_d = accept ? offs : wrAddr_q;
    rdata_d  = rdata_q;
    if (rdAccept) begin
      case (offs)
        `LSOC_OFS_CTRL0: rdata_d = {24'h00_0000, ctrl0_q};
        `LSOC_OFS_CTRL1: rdata_d = {24'h00_0000, ctrl1_q};
        `LSOC_OFS_GATE:  rdata_d = {31'h0000_0000, gateLvl_q};
        `LSOC_OFS_STAT:  rdata_d = {28'h000_0000, armed_q, lpcRstActive, pdLevel,
                                    shdn_q == SHDN_DOWN};
        default:         rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 12'h000;
      rdata_q  <= 32'h0000_0000;
    end else begin
      wrPend_q <= wrPend_d;
      wrAddr_q <= wrAddr_d;
      rdata_q  <= rdata_d;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  assign wd      = hwdata[7:0];
  assign wrCtrl0 = wrPend_q && (wrAddr_q == `LSOC_OFS_CTRL0);
  assign wrCtrl1 = wrPend_q && (wrAddr_q == `LSOC_OFS_CTRL1);
  assign wrGate  = wrPend_q && (wrAddr_q == `LSOC_OFS_GATE);
  assign ifReset = lpcRstActive | ctrl1_q[`LSOC_C1_SWRST];

  // Control register next values
  always_comb begin
    ctrl0_d   = ctrl0_q;
    ctrl1_d   = ctrl1_q;
    gateLvl_d = gateLvl_q;
    armed_d   = armed_q;
    if (wrCtrl0) begin
      ctrl0_d = (wd & `LSOC_C0_MASK);  // [RULE17]
      ctrl0_d[`LSOC_C0_SDWN] = wd[`LSOC_C0_SDWN] &
                               (ctrl0_q[`LSOC_C0_SDWN] | armed_q);  // [RULE5] [RULE6]
      armed_d = 1'b0;
    end
    // Reading the shutdown bit as 0 arms the set; arming wins over a disarm
    if (rdAccept && offs == `LSOC_OFS_CTRL0 && !ctrl0_q[`LSOC_C0_SDWN]) begin
      armed_d = 1'b1;  // [RULE6]
    end
    if (wrCtrl1) begin
      ctrl1_d = wd & `LSOC_C1_MASK;
    end
    if (wrGate) begin
      gateLvl_d = wd[`LSOC_GATE_LVL];
    end
    // Interface reset and shutdown release drop the enable
    if (ifReset || pdRise) begin
      ctrl0_d[`LSOC_C0_SDWN] = 1'b0;  // [RULE5]
    end
    // Gate state held at 1 while fast gate is off
    if (!ctrl0_d[`LSOC_C0_FGATE]) begin
      gateLvl_d = `LSOC_GATE_RST;  // [RULE1]
    end
    if (standby) begin
      ctrl0_d   = `LSOC_CTRL_RST;  // [RULE16]
      ctrl1_d   = `LSOC_CTRL_RST;
      gateLvl_d = `LSOC_GATE_RST;
      armed_d   = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl0_q   <= `LSOC_CTRL_RST;  // [RULE16]
      ctrl1_q   <= `LSOC_CTRL_RST;
      gateLvl_q <= `LSOC_GATE_RST;
      armed_q   <= 1'b0;
    end else begin
      ctrl0_q   <= ctrl0_d;
      ctrl1_q   <= ctrl1_d;
      gateLvl_q <= gateLvl_d;
      armed_q   <= armed_d;
    end
  end

  // Hardware shutdown state
  always_comb begin
    shdn_d = shdn_q;
    case (shdn_q)
      SHDN_RUN: begin
        if (ctrl0_q[`LSOC_C0_SDWN] && !pdLevel && !ifReset) begin
          shdn_d = SHDN_DOWN;  // [RULE7]
        end
      end
      SHDN_DOWN: begin
        if (pdLevel || ifReset) begin
          shdn_d = SHDN_RUN;
        end
      end
      default: shdn_d = SHDN_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shdn_q <= SHDN_RUN;
    end else begin
      shdn_q <= shdn_d;
    end
  end

  assign hwShutdown      = (shdn_q == SHDN_DOWN);
  assign addr20GateState = gateLvl_q;

  // Open-drain drivers: gate, power event, management irq, control irq
  lsoc_od_pins #(
    .WIDTH (4)
  ) u_pins (
    .clk    (clk),
    .rstn   (rstn),
    .enable ({ctrl0_q[`LSOC_C0_FGATE], ctrl0_q[`LSOC_C0_PME],
              ctrl0_q[`LSOC_C0_SMI],   ctrl0_q[`LSOC_C0_SCI]}),  // [RULE2] [RULE8] [RULE10] [RULE12]
    .level  ({gateLvl_q,               ctrl1_q[`LSOC_C1_PMEL],
              ctrl1_q[`LSOC_C1_SMIL],  ctrl1_q[`LSOC_C1_SCIL]}),  // [RULE9] [RULE11] [RULE13]
    .pinSel ({gatePinSel, pmePinSel, smiPinSel, sciPinSel}),
    .pinOut ({gatePinOut, pmePinOut, smiPinOut, sciPinOut}),      // [RULE14]
    .pinOe  ({gatePinOe,  pmePinOe,  smiPinOe,  sciPinOe})
  );

  // Checks on the control bits and pins
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_gate_off_released: assert property (  // [RULE1]
    !ctrl0_q[`LSOC_C0_FGATE] |-> gateLvl_q ##1 (!gatePinSel && !gatePinOe))
    else $error("gate pin not released while fast gate off");

  a_gate_od_low: assert property (  // [RULE2]
    (ctrl0_q[`LSOC_C0_FGATE] && !gateLvl_q) |=> (gatePinSel && gatePinOe && !gatePinOut))
    else $error("gate pin not pulled low");

  a_sdwn_write_zero: assert property (  // [RULE5]
    (wrCtrl0 && !wd[`LSOC_C0_SDWN]) |=> !ctrl0_q[`LSOC_C0_SDWN])
    else $error("shutdown enable survived a written zero");

  a_sdwn_release_clr: assert property (  // [RULE5]
    (pdRise || ifReset) |=> !ctrl0_q[`LSOC_C0_SDWN])
    else $error("shutdown enable survived reset or release");

  a_sdwn_set_armed: assert property (  // [RULE6]
    $rose(ctrl0_q[`LSOC_C0_SDWN]) |-> $past(wrCtrl0 && armed_q && wd[`LSOC_C0_SDWN]))
    else $error("shutdown enable set without read of zero");

  a_shdn_entry: assert property (  // [RULE7]
    (shdn_q == SHDN_RUN && ctrl0_q[`LSOC_C0_SDWN] && !pdLevel && !ifReset)
      |=> hwShutdown)
    else $error("hardware shutdown not entered");

  a_pme_pin: assert property (  // [RULE8] [RULE9]
    1'b1 |=> (pmePinSel == $past(ctrl0_q[`LSOC_C0_PME])) &&
             (pmePinOe == $past(ctrl0_q[`LSOC_C0_PME] && !ctrl1_q[`LSOC_C1_PMEL])))
    else $error("power event pin mismatch");

  a_smi_pin: assert property (  // [RULE10] [RULE11]
    1'b1 |=> (smiPinSel == $past(ctrl0_q[`LSOC_C0_SMI])) &&
             (smiPinOe == $past(ctrl0_q[`LSOC_C0_SMI] && !ctrl1_q[`LSOC_C1_SMIL])))
    else $error("management irq pin mismatch");

  a_sci_pin: assert property (  // [RULE12] [RULE13]
    1'b1 |=> (sciPinSel == $past(ctrl0_q[`LSOC_C0_SCI])) &&
             (sciPinOe == $past(ctrl0_q[`LSOC_C0_SCI] && !ctrl1_q[`LSOC_C1_SCIL])))
    else $error("control irq pin mismatch");

  a_never_high: assert property (  // [RULE14]
    !pmePinOut && !smiPinOut && !sciPinOut && !gatePinOut)
    else $error("sideband pin driven high");

  a_standby_clear: assert property (  // [RULE16]
    standby |=> (ctrl0_q == `LSOC_CTRL_RST) && (ctrl1_q == `LSOC_CTRL_RST))
    else $error("control registers not cleared in standby");

  a_enable_readback: assert property (  // [RULE17]
    (wrCtrl0 && !standby) |=> (ctrl0_q[2:0] == $past(wd[2:0])) &&
                              (ctrl0_q[`LSOC_C0_FGATE] == $past(wd[`LSOC_C0_FGATE])))
    else $error("enable bits do not hold written value");

  // Gate level follows a write while the fast gate owns the pin
  a_gate_level_write: assert property (  // [RULE2]
    (wrGate && ctrl0_q[`LSOC_C0_FGATE] && !standby)
      |=> (addr20GateState == $past(wd[`LSOC_GATE_LVL])))
    else $error("gate level did not follow write");

  a_shdn_exit: assert property (  // [RULE7]
    (hwShutdown && (pdLevel || ifReset)) |=> !hwShutdown)
    else $error("hardware shutdown not left");

endmodule

`default_nettype wire

// *** dv/lsoc_host_model.sv ***
// Purpose: Chipset end of the open-drain sideband lines
// Assumes: Each line has a pull-up; bit 3 gate, 2 power event, 1 mgmt irq, 0 ctrl irq
// Notes:   Purely combinational wire resolution
`timescale 1ns/1ps
`default_nettype none

module lsoc_host_model (
  input  wire logic [3:0] pinSel,     // Function owns the pin
  input  wire logic [3:0] pinOut,     // Pin data from the block
  input  wire logic [3:0] pinOe,      // Pin output enable
  input  wire logic [3:0] portDir,    // Firmware port direction, 1 = output
  input  wire logic [3:0] portOut,    // Firmware port output level
  output logic      [3:0] wireLvl,    // Level seen by the chipset
  output logic      [3:0] drivenHigh  // Block drives a line high
);
  logic [3:0] reach;
  // Gate reaches its line with direction 0, sideband lines with direction 1
  assign reach      = pinSel & {~portDir[3], portDir[2:0]};
  // Pull-up holds the line unless an owned pin sinks it
  // or a plain port output drives it low
  assign wireLvl    = ~(reach & pinOe & ~pinOut) & ~(~pinSel & portDir & ~portOut);
  // An active high drive would fight the pull-up
  assign drivenHigh = pinSel & pinOe & pinOut;
endmodule

`default_nettype wire

// *** dv/tb_lsoc_sideband.sv ***
// Purpose: Self-checking bench for the sideband output control block
// Assumes: One AHB-Lite master, zero wait slave, pins pulled up
// Notes:   Each scenario is one task; inputs change by NBA after the edge
`timescale 1ns/1ps
`default_nettype none
`include "lsoc_params.svh"

module tb_lsoc_sideband
  import lsoc_pkg::*;
;
  `define CHK(nm, ex, gt) begin nTests++; if ((gt) !== (ex)) begin mismatches++; \
    $display("BAD %s exp %0h seen %0h", nm, ex, gt); end end

  localparam logic [31:0] addrC0  = 32'(`LSOC_OFS_CTRL0);
  localparam logic [31:0] addrC1  = 32'(`LSOC_OFS_CTRL1);
  localparam logic [31:0] addrGt  = 32'(`LSOC_OFS_GATE);
  localparam logic [31:0] addrSt  = 32'(`LSOC_OFS_STAT);
  localparam logic [31:0] addrBad = 32'h0000_0010;

  logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0;
  logic [1:0]  htrans = HTRANS_IDLE;
  logic [2:0]  hsize = 3'h2;
  logic        powerDownInN = 1'b1, lpcResetInN = 1'b1, standbyInN = 1'b1;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, hwShutdown, addr20GateState;
  wire  logic [3:0] pinSel, pinOut, pinOe, wireLvl, drivenHigh;
  // Firmware starts with gate direction 0 and sideband directions 1; tGate sets gate direction 1 once for a port drive
  logic [3:0]  portDir = 4'h7, portOut = 4'hF;
  wire  logic  hready;
  int          mismatches = 0;
  int          nTests = 0;

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  lsoc_sideband u_lsoc_sideband (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .powerDownInN(powerDownInN), .lpcResetInN(lpcResetInN), .standbyInN(standbyInN),
    .hwShutdown(hwShutdown), .addr20GateState(addr20GateState),
    .gatePinSel(pinSel[3]), .gatePinOut(pinOut[3]), .gatePinOe(pinOe[3]),
    .pmePinSel(pinSel[2]), .pmePinOut(pinOut[2]), .pmePinOe(pinOe[2]),
    .smiPinSel(pinSel[1]), .smiPinOut(pinOut[1]), .smiPinOe(pinOe[1]),
    .sciPinSel(pinSel[0]), .sciPinOut(pinOut[0]), .sciPinOe(pinOe[0])
  );

  lsoc_host_model u_lsoc_host_model (
    .pinSel(pinSel), .pinOut(pinOut), .pinOe(pinOe),
    .portDir(portDir), .portOut(portOut),
    .wireLvl(wireLvl), .drivenHigh(drivenHigh)
  );

  // Clock, 8 ns period
  always #4 clk = ~clk;

  // Verdict and end of run
  task automatic summarize();
    if (mismatches == 0 && nTests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Bounded wait for bus ready at a rising edge
  task automatic waitReady();
    int k;
    k = 0;
    @(posedge clk);
    while (hready !== 1'b1 && k <= 50) begin
      k++;
      @(posedge clk);
    end
    if (k > 50) begin
      mismatches++;
      summarize();
    end
  endtask

  // One single word transfer, address then data phase
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    waitReady();
    hsel   <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    waitReady();
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] v;
    ahb(1'b1, a, d, v);
  endtask

  task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] ex);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0000_0000, v);
    `CHK(nm, ex, v)
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Ownership, enables, wire levels, never a high drive
  task automatic chkPins(input logic [3:0] eSel, input logic [3:0] eOe);
    `CHK("pinSel", eSel, pinSel)
    `CHK("pinOe", eOe, pinOe)
    `CHK("wireLvl", ~(eSel & eOe), wireLvl)
    `CHK("pinOut", 4'h0, pinOut)
    `CHK("drivenHigh", 4'h0, drivenHigh)
  endtask

  task automatic tReset();
    rdchk("ctrl0", addrC0, 32'h0000_0000);
    rdchk("ctrl1", addrC1, 32'h0000_0000);
    `CHK("gateState", 1'b1, addr20GateState)
    `CHK("hreadyout", 1'b1, hreadyout)
    `CHK("hresp", 1'b0, hresp)
    chkPins(4'h0, 4'h0);
  endtask

  // Every enable and level combination of the three sideband pins
  task automatic tSideband();
    for (int e = 0; e < 8; e++) begin
      for (int l = 0; l < 8; l++) begin
        wr(addrC1, 32'(l));
        wr(addrC0, 32'(e));
        hold(3);
        chkPins({1'b0, 3'(e)}, {1'b0, 3'(e) & ~3'(l)});
        rdchk("ctrl0", addrC0, 32'(e));
      end
    end
    wr(addrC1, 32'h0000_0000);
    wr(addrC0, 32'h0000_0000);
  endtask

  task automatic tGate();
    wr(addrC0, 32'h0000_0010);
    wr(addrGt, 32'h0000_0000);
    hold(3);
    `CHK("gateState", 1'b0, addr20GateState)
    chkPins(4'h8, 4'h8);
    rdchk("ctrl0", addrC0, 32'h0000_0010);
    wr(addrC0, 32'h0000_0000);
    hold(3);
    `CHK("gateState", 1'b1, addr20GateState)
    chkPins(4'h0, 4'h0);
    portDir[3] <= 1'b1;
    portOut[3] <= 1'b0;
    hold(1);
    `CHK("gateByPort", 1'b0, wireLvl[3])
    portDir[3] <= 1'b0;
    portOut[3] <= 1'b1;
    rdchk("gate", addrGt, 32'h0000_0001);
  endtask

  task automatic tShutdown();
    powerDownInN <= 1'b0;
    hold(6);
    `CHK("hwShutdown", 1'b0, hwShutdown)
    powerDownInN <= 1'b1;
    hold(6);
    wr(addrC0, 32'h0000_0008);
    rdchk("ctrl0", addrC0, 32'h0000_0000);
    rdchk("status", addrSt, 32'h0000_000A);
    wr(addrC0, 32'h0000_0008);
    rdchk("ctrl0", addrC0, 32'h0000_0008);
    wr(addrC0, 32'h0000_0000);
    rdchk("ctrl0", addrC0, 32'h0000_0000);
    wr(addrC0, 32'h0000_0008);
    powerDownInN <= 1'b0;
    hold(6);
    `CHK("hwShutdown", 1'b1, hwShutdown)
    rdchk("status", addrSt, 32'h0000_0001);
    powerDownInN <= 1'b1;
    hold(6);
    `CHK("hwShutdown", 1'b0, hwShutdown)
    rdchk("ctrl0", addrC0, 32'h0000_0000);
    wr(addrC0, 32'h0000_0008);
    wr(addrC1, 32'h0000_0010);
    hold(3);
    wr(addrC1, 32'h0000_0000);
    hold(3);
    rdchk("ctrl0", addrC0, 32'h0000_0000);
    wr(addrC0, 32'h0000_0008);
    lpcResetInN <= 1'b0;
    hold(6);
    rdchk("status", addrSt, 32'h0000_0006);
    lpcResetInN <= 1'b1;
    hold(6);
    rdchk("ctrl0", addrC0, 32'h0000_0000);
  endtask

  task automatic tStandby();
    wr(addrC0, 32'h0000_0017);
    wr(addrC1, 32'h0000_0007);
    wr(addrBad, 32'h0000_00ff);
    rdchk("unmapped", addrBad, 32'h0000_0000);
    standbyInN <= 1'b0;
    hold(6);
    standbyInN <= 1'b1;
    hold(6);
    rdchk("ctrl0", addrC0, 32'h0000_0000);
    rdchk("ctrl1", addrC1, 32'h0000_0000);
    chkPins(4'h0, 4'h0);
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    tReset();
    tSideband();
    tGate();
    tShutdown();
    tStandby();
    summarize();
  end

  // Watchdog on the whole run
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule

`default_nettype wire
